// >>> verilog/hbp_pkg.sv
// shared constants and carriers for the host byte port
`default_nettype none
package hbp_pkg;

  // ----------------------------------------------------------------
  // core-side word indices (eight consecutive locations)
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_BASE   = 3'h0; // base_address_reg
  localparam logic [2:0] IDX_PORT   = 3'h1; // port_control_reg
  localparam logic [2:0] IDX_CTRL   = 3'h2; // core_control_reg
  localparam logic [2:0] IDX_STAT   = 3'h3; // core_status_reg
  localparam logic [2:0] IDX_DIR    = 3'h4; // pin_direction_reg
  localparam logic [2:0] IDX_VAL    = 3'h5; // pin_value_reg
  localparam logic [2:0] IDX_RXWORD = 3'h6; // host_to_core_rx_word
  localparam logic [2:0] IDX_TXWORD = 3'h7; // core_to_host_tx_word

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST_RXF   = 0; // core_rx_full_flag
  localparam int ST_TXE   = 1; // core_tx_empty_flag
  localparam int CT_RIE   = 0; // rx_irq_enable
  localparam int CT_TIE   = 1; // tx_irq_enable
  localparam int PC_EN    = 0; // port enable
  localparam int PC_MUX   = 1; // multiplexed address/data bus
  localparam int PC_DUAL  = 2; // separate read and write strobes
  localparam int PC_NOVEC = 3; // separate request outputs
  localparam int PC_HA8   = 4; // upper_addr_line_8 used by the port
  localparam int PC_HA9   = 5; // upper_addr_line_9 used by the port
  localparam int PC_CS    = 6; // port_select_pin used by the port
  localparam int PC_REQ   = 7; // request pin used by the port
  localparam int PC_ACK   = 8; // acknowledge/receive request pin used
  localparam int HC_RREQ  = 0; // host ctrl: receive request enable
  localparam int HC_TREQ  = 1; // host ctrl: transmit request enable
  localparam int HS_RXF   = 0; // host status: hostside_rx_full_flag
  localparam int HS_TXE   = 1; // host status: hostside_tx_empty_flag

  // ----------------------------------------------------------------
  // pin numbers of the upper eight host pins, 8 to 15
  // ----------------------------------------------------------------
  localparam int PIN_AS   = 8;  // address_strobe_pin / low_addr_line_0
  localparam int PIN_A8   = 9;
  localparam int PIN_A9   = 10;
  localparam int PIN_RW   = 11; // read_write_select_pin / read_strobe_pin
  localparam int PIN_DS   = 12; // data_strobe_pin / write_strobe_pin
  localparam int PIN_CS   = 13;
  localparam int PIN_REQ  = 14;
  localparam int PIN_ACK  = 15;

  // ----------------------------------------------------------------
  // host byte addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  HA_CTRL  = 3'h0;
  localparam logic [2:0]  HA_STAT  = 3'h2;
  localparam logic [2:0]  HA_HIGH  = 3'h5;
  localparam logic [2:0]  HA_MID   = 3'h6;
  localparam logic [2:0]  HA_LOW   = 3'h7;
  localparam logic [15:0] REG16_RST = 16'h0000;
  localparam logic [23:0] WORD_RST  = 24'h000000;
  localparam int          STAT_DELAY = 2; // core write to status update

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic [2:0]  idx;
    logic [23:0] wdata;
  } hbp_req_s;

  typedef struct packed {
    logic [2:0]  idx;
    logic [23:0] rdata;
  } hbp_rsp_s;

endpackage
`default_nettype wire

// >>> verilog/hbp_buf2.sv
// two-entry buffer on the core answer path
`timescale 1ns/10ps
`default_nettype none
module hbp_buf2
  import hbp_pkg::*;
#(
  parameter int W     = $bits(hbp_rsp_s),
  parameter int DEPTH = 2
) (
  input  wire logic         mclk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output var  logic         in_ready_out,
  output var  logic         out_valid_out,
  output var  logic [W-1:0] out_data_out,
  input  wire logic         out_ready_in
);

  logic [W-1:0] mem_q [DEPTH];
  logic [1:0]   cnt_q;
  logic [1:0]   cnt_d;
  logic [1:0]   left;
  logic         push;
  logic         pop;

  // entry 0 is the head, entry 1 holds a word caught during a stall
  assign push  = in_valid_in & in_ready_out;
  assign pop   = out_valid_out & out_ready_in;
  assign left  = cnt_q - {1'b0, pop};
  assign cnt_d = left + {1'b0, push};
  assign out_data_out = mem_q[0];

  // occupancy with registered ready and valid
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_q         <= 2'h0;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      cnt_q         <= cnt_d;
      in_ready_out  <= (cnt_d != 2'(DEPTH));
      out_valid_out <= (cnt_d != 2'h0);
    end
  end

  // storage: shift the tail forward on a pop
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else begin
      if (pop && cnt_q == 2'h2)
        mem_q[0] <= mem_q[1];
      else if (push && left == 2'h0)
        mem_q[0] <= in_data_in;
      if (push && left == 2'h1)
        mem_q[1] <= in_data_in;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/hbp_top.sv
// host byte port: core-side registers, host byte bank and pin roles
//
// How it works
// - host byte bank and core word bank are separate register sets
// - core side decodes eight consecutive 24-bit word locations
// - host side decodes five of its eight byte addresses, 8 bits per access
// - five control registers are 16 bits; core reads upper bits zero
// - host triplet copies to core rx word when both flags clear
// - that copy sets host tx empty and core rx full together
// - core read of rx word clears rx full; word valid while set
// - rx irq enable and rx full raise receive interrupt request
// - rx full presents a core dma read request
// - core write of tx word clears core tx empty
// - core tx word moves to host rx triplet when both flags clear
// - that move sets host rx full and core tx empty
// - tx irq enable and tx empty raise transmit interrupt request
// - tx empty presents a core dma write request
// - status changed by a core write updates two cycles later
// - hardware and software reset both disable the port
// - after reset all host pins are general pins, undriven
// - port unused: all sixteen pins are general pins 0 to 15
// - port used: only five pins may each return to general use
// - pins serve multiplexed or non-multiplexed host bus
// - strobes are rw select plus data strobe, or read and write
// - request pins: combined request plus ack, or two requests
// - status register: rx full bit 0, tx empty bit 1
// - control register: rx irq enable bit 0, tx irq enable bit 1
`timescale 1ns/10ps
`default_nettype none
module hbp_top
  import hbp_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        soft_rst_in,
  input  wire logic        core_req_valid_in,
  input  wire hbp_req_s    core_req_in,
  output var  logic        core_req_ready_out,
  output var  logic        core_rsp_valid_out,
  output var  hbp_rsp_s    core_rsp_out,
  input  wire logic        core_rsp_ready_in,
  output var  logic        rx_irq_out,
  output var  logic        tx_irq_out,
  output var  logic        rx_dma_req_out,
  output var  logic        tx_dma_req_out,
  input  wire logic [15:0] pin_in,
  output var  logic [15:0] pin_out,
  output var  logic [15:0] pin_oe_out
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // read strobe active; v = {cs, ds/wr, rw/rd, as}, active low except rw select, high for read
  function automatic logic rd_act(input logic dual, input logic [3:0] v);
    rd_act = dual ? !v[1] : (!v[2] && v[1]);
  endfunction

  function automatic logic wr_act(input logic dual, input logic [3:0] v);
    wr_act = dual ? !v[2] : (!v[2] && !v[1]);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] ctrl_q;        // core_control_reg
  logic [15:0] port_q;        // port_control_reg
  logic [15:0] base_q;        // base_address_reg
  logic [15:0] dir_q;         // pin_direction_reg
  logic [15:0] val_q;         // pin_value_reg
  logic [23:0] rx_word_q;     // host_to_core_rx_word
  logic [23:0] tx_word_q;     // core_to_host_tx_word
  logic        rxf_q;         // core_rx_full_flag
  logic        txe_q;         // core_tx_empty_flag
  logic [STAT_DELAY-1:0] txw_pipe_q;
  logic [23:0] h_tx_trip_q;   // hostside_tx_byte_triplet
  logic [23:0] h_rx_trip_q;   // hostside_rx_byte_triplet
  logic        h_txe_q;       // hostside_tx_empty_flag
  logic        h_rxf_q;       // hostside_rx_full_flag
  logic [1:0]  h_ctl_q;
  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  logic [3:0]  sync3_q;
  logic [2:0]  mux_addr_q;
  logic        mux_match_q;
  logic [7:0]  rd_byte_q;

  logic        en;
  logic        take;
  logic        rd_rx;
  logic        wr_tx;
  logic        copy_in;
  logic        move_out;
  logic [2:0]  h_addr;
  logic        h_sel;
  logic        h_rd_start;
  logic        h_wr_start;
  logic        h_drive;
  logic [7:0]  h_data;
  logic [23:0] rdata;
  logic [15:0] role;
  logic [15:0] pin_out_d;
  logic [15:0] pin_oe_d;
  logic        tx_rq;
  logic        rx_rq;
  hbp_rsp_s    rsp_d;

  assign en = port_q[PC_EN];

  // ----------------------------------------------------------------
  // core register access
  // ----------------------------------------------------------------
  // every taken request pushes one answer into the buffer
  assign take  = core_req_valid_in & core_req_ready_out;
  assign rd_rx = take && !core_req_in.wr
              && core_req_in.idx == IDX_RXWORD;
  assign wr_tx = take && core_req_in.wr
              && core_req_in.idx == IDX_TXWORD;

  // read mux: 16-bit registers return zero above bit 15
  always_comb begin
    rdata = WORD_RST;
    case (core_req_in.idx)
      IDX_BASE:   rdata = {8'h00, base_q};
      IDX_PORT:   rdata = {8'h00, port_q};
      IDX_CTRL:   rdata = {8'h00, ctrl_q};
      IDX_STAT:   rdata = {22'h000000, txe_q, rxf_q};
      IDX_DIR:    rdata = {8'h00, dir_q};
      IDX_VAL:    rdata = {8'h00, (val_q & dir_q) | (pin_in & ~dir_q)};
      IDX_RXWORD: rdata = rx_word_q;
      default:    rdata = WORD_RST;
    endcase
    if (core_req_in.wr)
      rdata = WORD_RST;
  end

  assign rsp_d.idx   = core_req_in.idx;
  assign rsp_d.rdata = rdata;

  // answer buffer: a stalled reader back-pressures new requests
  hbp_buf2 u_buf (
    .mclk_in       (mclk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (core_req_valid_in),
    .in_data_in    (rsp_d),
    .in_ready_out  (core_req_ready_out),
    .out_valid_out (core_rsp_valid_out),
    .out_data_out  (core_rsp_out),
    .out_ready_in  (core_rsp_ready_in)
  );

  // writable control registers
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_q <= REG16_RST;
      port_q <= REG16_RST;
      base_q <= REG16_RST;
      dir_q  <= REG16_RST;
      val_q  <= REG16_RST;
    end else if (soft_rst_in) begin
      ctrl_q <= REG16_RST;
      port_q <= REG16_RST;
      base_q <= REG16_RST;
      dir_q  <= REG16_RST;
      val_q  <= REG16_RST;
    end else if (take && core_req_in.wr) begin
      case (core_req_in.idx)
        IDX_CTRL: ctrl_q <= core_req_in.wdata[15:0];
        IDX_PORT: port_q <= core_req_in.wdata[15:0];
        IDX_BASE: base_q <= core_req_in.wdata[15:0];
        IDX_DIR:  dir_q  <= core_req_in.wdata[15:0];
        IDX_VAL:  val_q  <= core_req_in.wdata[15:0];
        default:  ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // word transfers between the two banks
  // ----------------------------------------------------------------
  assign copy_in  = en && !h_txe_q && !rxf_q;
  assign move_out = en && !txe_q && !h_rxf_q;

  // core data words and flags; a set beats a simultaneous clear
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_word_q  <= WORD_RST;
      tx_word_q  <= WORD_RST;
      rxf_q      <= 1'b0;
      txe_q      <= 1'b1;
      txw_pipe_q <= '0;
    end else if (soft_rst_in) begin
      rxf_q      <= 1'b0;
      txe_q      <= 1'b1;
      txw_pipe_q <= '0;
    end else begin
      txw_pipe_q <= {txw_pipe_q[STAT_DELAY-2:0], wr_tx};
      if (wr_tx)
        tx_word_q <= core_req_in.wdata;
      if (copy_in) begin
        rx_word_q <= h_tx_trip_q;
        rxf_q     <= 1'b1;
      end else if (rd_rx) begin
        rxf_q     <= 1'b0;
      end
      if (move_out)
        txe_q <= 1'b1;
      else if (txw_pipe_q[STAT_DELAY-1])
        txe_q <= 1'b0;
    end
  end

  // interrupt and dma requests toward the core
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_irq_out     <= 1'b0;
      tx_irq_out     <= 1'b0;
      rx_dma_req_out <= 1'b0;
      tx_dma_req_out <= 1'b0;
    end else begin
      rx_irq_out     <= en && ctrl_q[CT_RIE] && rxf_q;
      tx_irq_out     <= en && ctrl_q[CT_TIE] && txe_q;
      rx_dma_req_out <= en && rxf_q;
      tx_dma_req_out <= en && txe_q;
    end
  end

  // ----------------------------------------------------------------
  // host strobe capture
  // ----------------------------------------------------------------
  // cs, data/write strobe, rw/read strobe and address strobe
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
      sync3_q <= 4'hF;
    end else begin
      sync1_q <= {pin_in[PIN_CS], pin_in[PIN_DS],
                  pin_in[PIN_RW], pin_in[PIN_AS]};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // multiplexed bus: latch address and base match on strobe fall
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mux_addr_q  <= 3'h0;
      mux_match_q <= 1'b0;
    end else if (port_q[PC_MUX] && !sync2_q[0] && sync3_q[0]) begin
      mux_addr_q  <= pin_in[2:0];
      mux_match_q <= {pin_in[PIN_CS], pin_in[PIN_A9], pin_in[PIN_A8],
                      pin_in[7:3]} == base_q[7:0];
    end
  end

  // decode the selected host byte address
  assign h_addr = port_q[PC_MUX] ? mux_addr_q
                : pin_in[PIN_A9:PIN_AS];
  assign h_sel  = en && (port_q[PC_MUX] ? mux_match_q : !sync2_q[3]);
  assign h_rd_start = h_sel && rd_act(port_q[PC_DUAL], sync2_q)
                   && !rd_act(port_q[PC_DUAL], sync3_q);
  assign h_wr_start = h_sel && wr_act(port_q[PC_DUAL], sync2_q)
                   && !wr_act(port_q[PC_DUAL], sync3_q);
  assign h_drive = h_sel && rd_act(port_q[PC_DUAL], sync2_q);
  assign h_data  = pin_in[7:0];

  // ----------------------------------------------------------------
  // host byte bank
  // ----------------------------------------------------------------
  // host writes fill the triplet; the low byte completes the word
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      h_tx_trip_q <= WORD_RST;
      h_ctl_q     <= 2'h0;
      h_txe_q     <= 1'b1;
    end else if (soft_rst_in) begin
      h_ctl_q     <= 2'h0;
      h_txe_q     <= 1'b1;
    end else begin
      if (h_wr_start) begin
        case (h_addr)
          HA_CTRL: h_ctl_q            <= h_data[1:0];
          HA_HIGH: h_tx_trip_q[23:16] <= h_data;
          HA_MID:  h_tx_trip_q[15:8]  <= h_data;
          HA_LOW:  h_tx_trip_q[7:0]   <= h_data;
          default: ;
        endcase
      end
      if (copy_in)
        h_txe_q <= 1'b1;
      else if (h_wr_start && h_addr == HA_LOW)
        h_txe_q <= 1'b0;
    end
  end

  // host rx triplet, its full flag and the byte driven on reads
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      h_rx_trip_q <= WORD_RST;
      h_rxf_q     <= 1'b0;
      rd_byte_q   <= 8'h00;
    end else if (soft_rst_in) begin
      h_rxf_q     <= 1'b0;
      rd_byte_q   <= 8'h00;
    end else begin
      if (move_out)
        h_rx_trip_q <= tx_word_q;
      if (move_out)
        h_rxf_q <= 1'b1;
      else if (h_rd_start && h_addr == HA_LOW)
        h_rxf_q <= 1'b0;
      if (h_rd_start) begin
        case (h_addr)
          HA_CTRL: rd_byte_q <= {6'h00, h_ctl_q};
          HA_STAT: rd_byte_q <= {6'h00, h_txe_q, h_rxf_q};
          HA_HIGH: rd_byte_q <= h_rx_trip_q[23:16];
          HA_MID:  rd_byte_q <= h_rx_trip_q[15:8];
          HA_LOW:  rd_byte_q <= h_rx_trip_q[7:0];
          default: rd_byte_q <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // pin roles
  // ----------------------------------------------------------------
  // a pin is a port pin only while enabled; five may stay general
  always_comb begin
    role = 16'h0000;
    if (en) begin
      role           = 16'h19FF;
      role[PIN_A8]   = port_q[PC_HA8];
      role[PIN_A9]   = port_q[PC_HA9];
      role[PIN_CS]   = port_q[PC_CS];
      role[PIN_REQ]  = port_q[PC_REQ];
      role[PIN_ACK]  = port_q[PC_ACK];
    end
  end

  assign tx_rq = h_txe_q && h_ctl_q[HC_TREQ];
  assign rx_rq = h_rxf_q && h_ctl_q[HC_RREQ];

  // drive values: general pins from registers, port pins by mode
  always_comb begin
    pin_out_d = val_q;
    pin_oe_d  = dir_q;
    for (int i = 0; i < 16; i++) begin
      if (role[i]) begin
        pin_out_d[i] = 1'b0;
        pin_oe_d[i]  = 1'b0;
      end
    end
    if (role[7]) begin
      pin_out_d[7:0] = rd_byte_q;
      pin_oe_d[7:0]  = {8{h_drive}};
    end
    if (role[PIN_REQ]) begin
      pin_out_d[PIN_REQ] = port_q[PC_NOVEC] ? !tx_rq : !(tx_rq || rx_rq);
      pin_oe_d[PIN_REQ]  = 1'b1;
    end
    if (role[PIN_ACK] && port_q[PC_NOVEC]) begin
      pin_out_d[PIN_ACK] = !rx_rq;
      pin_oe_d[PIN_ACK]  = 1'b1;
    end
  end

  // registered pin drivers; all undriven while sys_rst_in is high
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_out    <= 16'h0000;
      pin_oe_out <= 16'h0000;
    end else begin
      pin_out    <= pin_out_d;
      pin_oe_out <= pin_oe_d;
    end
  end

endmodule
`default_nettype wire

// >>> sim/hbp_top_asserts.sv
// checker on the host byte port top-level ports
`timescale 1ns/10ps
`default_nettype none
module hbp_top_asserts
  import hbp_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        sys_rst_in,
  input wire logic        soft_rst_in,
  input wire logic        core_req_valid_in,
  input wire hbp_req_s    core_req_in,
  input wire logic        core_req_ready_out,
  input wire logic        core_rsp_valid_out,
  input wire hbp_rsp_s    core_rsp_out,
  input wire logic        core_rsp_ready_in,
  input wire logic        rx_irq_out,
  input wire logic        tx_irq_out,
  input wire logic        rx_dma_req_out,
  input wire logic        tx_dma_req_out,
  input wire logic [15:0] pin_oe_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------------------------------
  // core requests taken
  // ----------------------------------------------------------------
  sequence s_take; core_req_valid_in && core_req_ready_out; endsequence
  sequence s_txw; s_take ##0 core_req_in.wr && core_req_in.idx == 3'h7;
  endsequence
  sequence s_rxrd; s_take ##0 !core_req_in.wr && core_req_in.idx == 3'h6;
  endsequence
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_rsp_holds: assert property (core_rsp_valid_out &&
    !core_rsp_ready_in |=> core_rsp_valid_out && $stable(core_rsp_out))
    else $error("answer not held");
  a_rsp_next: assert property (s_take ##0 !core_rsp_valid_out |=>
    core_rsp_valid_out && core_rsp_out.idx == $past(core_req_in.idx))
    else $error("answer late");
  a_refuse_full: assert property (!core_req_ready_out |->
    core_rsp_valid_out) else $error("refused while empty");
  a_ctrl_upper: assert property (core_rsp_valid_out &&
    core_rsp_out.idx < 3'h6 |-> core_rsp_out.rdata[23:16] == 8'h00)
    else $error("upper bits set");
  a_stat_bits: assert property (core_rsp_valid_out &&
    core_rsp_out.idx == 3'h3 |-> core_rsp_out.rdata[23:2] == 22'h0)
    else $error("status spare bits set");
  a_rx_irq_full: assert property (rx_irq_out |-> rx_dma_req_out)
    else $error("rx irq without full");
  a_tx_irq_empty: assert property (tx_irq_out |-> tx_dma_req_out)
    else $error("tx irq without empty");
  a_tx_write_late: assert property (s_txw ##0 tx_dma_req_out |=>
    tx_dma_req_out[*3] ##[1:3] !tx_dma_req_out) else $error("tx empty");
  a_rx_read_clears: assert property (s_rxrd ##0 rx_dma_req_out |->
    ##[1:3] !rx_dma_req_out) else $error("rx full kept");
  a_rst_pins_off: assert property ($fell(sys_rst_in) |->
    pin_oe_out == 16'h0000 && !tx_dma_req_out) else $error("pins driven");
  a_soft_off: assert property (soft_rst_in |-> ##2
    pin_oe_out == 16'h0000 && !tx_dma_req_out) else $error("port alive");
endmodule
bind hbp_top hbp_top_asserts u_chk (.mclk_in, .sys_rst_in, .soft_rst_in,
  .core_req_valid_in, .core_req_in, .core_req_ready_out,
  .core_rsp_valid_out, .core_rsp_out, .core_rsp_ready_in, .rx_irq_out,
  .tx_irq_out, .rx_dma_req_out, .tx_dma_req_out, .pin_oe_out);
`default_nettype wire

// >>> sim/hbp_host_model.sv
// host bus model: non-multiplexed bus, single or dual strobes, byte accesses
`timescale 1ns/10ps
`default_nettype none
module hbp_host_model
  import hbp_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic [15:0] pin_drv_in,
  input  wire logic [15:0] pin_oe_in,
  output var  logic [15:0] pin_lvl_out
);
  // idle: select, strobes and pulled-up requests high
  logic [15:0] host_q = 16'hF85A;
  // single-strobe bus: rw select on pin 11, data strobe on pin 12
  logic        ss     = 1'b0;
  // pin level: an enabled design driver wins over the host
  assign pin_lvl_out = (pin_oe_in & pin_drv_in) | (~pin_oe_in & host_q);
  // one byte access; released data lines show the inverse of last value
  task automatic host_acc(input logic rd, input logic [2:0] a,
                          input logic [7:0] d, output logic [7:0] x);
    @(posedge mclk_in);
    host_q <= {3'b110, rd & ~ss, ~(rd ^ ss), a,
               rd ? host_q[7:0] : d};
    repeat (6) @(posedge mclk_in);
    x = pin_lvl_out[7:0];
    host_q <= {8'hF8, ~pin_lvl_out[7:0]};
    repeat (6) @(posedge mclk_in);
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the host byte port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import hbp_pkg::*;
  logic        mclk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        soft_rst_in = 1'b0;
  logic        core_req_valid_in = 1'b0;
  hbp_req_s    core_req_in = '0;
  logic        core_rsp_ready_in = 1'b0;
  logic        core_req_ready_out, core_rsp_valid_out;
  hbp_rsp_s    core_rsp_out;
  logic        rx_irq_out, tx_irq_out, rx_dma_req_out, tx_dma_req_out;
  logic [15:0] pin_in, pin_out, pin_oe_out;
  logic [23:0] r, w;
  logic [23:0] q[$];
  int          seed = 32'h64C1;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          rdy_mode = 0;
  int          n;
  hbp_top uut (.mclk_in, .sys_rst_in, .soft_rst_in, .core_req_valid_in,
    .core_req_in, .core_req_ready_out, .core_rsp_valid_out, .core_rsp_out,
    .core_rsp_ready_in, .rx_irq_out, .tx_irq_out, .rx_dma_req_out,
    .tx_dma_req_out, .pin_in, .pin_out, .pin_oe_out);
  hbp_host_model host (.mclk_in, .pin_drv_in(pin_out),
    .pin_oe_in(pin_oe_out), .pin_lvl_out(pin_in));
  // ----------------------------------------------------------------
  // clock, answer-side stalls and shared tasks
  // ----------------------------------------------------------------
  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
    core_rsp_ready_in <= rdy_mode == 0 ? 1'($random(seed)) : rdy_mode == 2;
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic take_rsp();
    do @(posedge mclk_in); while (!(core_rsp_valid_out && core_rsp_ready_in));
    r = core_rsp_out.rdata;
  endtask
  task automatic cop(input logic wr, input logic [2:0] ix, input logic [23:0] d);
    core_req_valid_in <= 1'b1;
    core_req_in <= '{wr, ix, d};
    do @(posedge mclk_in); while (!core_req_ready_out);
    core_req_valid_in <= 1'b0;
    take_rsp();
  endtask
  task automatic hbyte(input logic rd, input int b, inout logic [23:0] v);
    logic [7:0] x;
    host.host_acc(rd, HA_HIGH + 3'(b), v[23-8*b -: 8], x);
    if (rd) v[23-8*b -: 8] = x;
  endtask
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk_in);
    n_mismatch++;
    $display("unexpected at %0t: run hung", $time);
    wrap_up();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    chk({8'h00, pin_oe_out}, 24'h0);
    for (int i = 0; i < 6; i++) begin
      w = 24'($random(seed));
      cop(1'b1, 3'(i), w);
      cop(1'b0, 3'(i), 24'h0);
      chk({r[23:16], 16'h0}, 24'h0);
      chk(r, i == 3 ? 24'h2 : {8'h00, i == 5 ? r[15:0] : w[15:0]});
    end
    soft_rst_in <= 1'b1;
    @(posedge mclk_in);
    soft_rst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    for (int i = 0; i < 6; i++) begin
      cop(1'b0, 3'(i), 24'h0);
      chk(r, i == 3 ? 24'h2 : i == 5 ? {8'h00, pin_in} : 24'h0);
    end
    cop(1'b1, IDX_PORT, 24'h000045);
    cop(1'b1, IDX_CTRL, 24'h000003);
    repeat (4) @(posedge mclk_in);
    chk({20'h0, tx_irq_out, tx_dma_req_out, rx_irq_out, rx_dma_req_out},
        24'hC);
    rdy_mode = 2;
    for (int k = 0; k < 2; k++) begin
      w = 24'($random(seed));
      q.push_back(w);
      cop(1'b1, IDX_TXWORD, w);
      cop(1'b0, IDX_STAT, 24'h0);
      chk(r, 24'h2);
      repeat (6) @(posedge mclk_in);
    end
    cop(1'b0, IDX_STAT, 24'h0);
    chk(r, 24'h0);
    repeat (2) begin
      for (int b = 0; b < 3; b++) hbyte(1'b1, b, r);
      chk(r, q.pop_front());
    end
    cop(1'b0, IDX_STAT, 24'h0);
    chk(r, 24'h2);
    repeat (2) begin
      w = 24'($random(seed));
      q.push_back(w);
      for (int b = 0; b < 3; b++) hbyte(1'b0, b, w);
    end
    chk({22'h0, rx_irq_out, rx_dma_req_out}, 24'h3);
    repeat (2) begin
      cop(1'b0, IDX_RXWORD, 24'h0);
      chk(r, q.pop_front());
      repeat (8) @(posedge mclk_in);
    end
    chk({22'h0, rx_irq_out, rx_dma_req_out}, 24'h0);
    // request pins in no-vector mode, then a single-strobe host write
    cop(1'b1, IDX_PORT, 24'h0001CD);
    host.host_acc(1'b0, HA_CTRL, 8'h02, r[7:0]);
    chk({20'h0, pin_oe_out[15:14], pin_in[15:14]}, 24'hE);
    host.ss = 1'b1;
    cop(1'b1, IDX_PORT, 24'h0001C9);
    w = 24'($random(seed));
    for (int b = 0; b < 3; b++) hbyte(1'b0, b, w);
    cop(1'b0, IDX_RXWORD, 24'h0);
    chk(r, w);
    // fill the answer buffer with the reader stalled, then drain it
    rdy_mode = 1;
    @(posedge mclk_in);
    core_req_in <= '{1'b0, IDX_STAT, 24'h0};
    core_req_valid_in <= 1'b1;
    n = 0;
    repeat (6) begin
      @(posedge mclk_in);
      n += int'(core_req_ready_out);
    end
    chk({23'h0, core_req_ready_out}, 24'h0);
    chk(24'(n), 24'h2);
    core_req_valid_in <= 1'b0;
    rdy_mode = 0;
    repeat (n) begin
      take_rsp();
      chk(r, 24'h2);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
